//--- verilog/ledbr_top.sv
// Purpose: Write-only I2C slave with four LED control registers.
// Assumes: SCL and SDA arrive async; oversampled by 40 MHz mclk.
// Notes:   Gain choice uses comparator flags from the analog side.
`include "ledbr_defs.svh"

module ledbr_top (
  // Clock and system reset
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  // Hardware reset pin, async
  input  wire logic                   hw_reset_n,
  // Address option strap, async
  input  wire logic                   addr_alt_strap,
  // Serial bus pins
  input  wire logic                   scl_in,
  input  wire logic                   sda_in,
  output logic                        sda_out,
  output logic                        sda_oe,
  // Low-headroom comparator flags, async
  input  wire ledbr_pkg::ledbr_sinks_t headroom_low,
  // Sink drive and scale
  output ledbr_pkg::ledbr_drive_t     drive,
  output ledbr_pkg::ledbr_scale_t     scale,
  // Sense gating and pump gain
  output ledbr_pkg::ledbr_sinks_t     sense_en,
  output logic                        gain_boost,
  // Register views
  output logic [7:0]                  enable_control,
  output logic [7:0]                  main_bank_level_reg,
  output logic [7:0]                  aux_bank_level_reg,
  output logic [7:0]                  indicator_level_reg
);
  import ledbr_pkg::*;

  // Whole state of the slave
  typedef struct packed {
    logic         scl_s1;     // SCL sync stage 1
    logic         scl_s2;     // SCL sync stage 2
    logic         scl_d;      // SCL delayed for edges
    logic         sda_s1;     // SDA sync stage 1
    logic         sda_s2;     // SDA sync stage 2
    logic         sda_d;      // SDA delayed for edges
    logic         rst_s1;     // Reset pin stage 1
    logic         rst_s2;     // Reset pin stage 2
    logic         strap_s1;   // Strap stage 1
    logic         strap_s2;   // Strap stage 2
    logic [1:0]   strap_cnt;  // Strap capture wait
    logic         addr_alt;   // Captured address option
    ledbr_sinks_t hr_s1;      // Headroom stage 1
    ledbr_sinks_t hr_s2;      // Headroom stage 2
    ledbr_phase_t phase;      // Transaction phase
    logic [3:0]   bitcnt;     // Bits of current byte
    logic         ack_phase;  // Inside ninth clock
    logic         ack_drive;  // Pulling SDA low
    logic [7:0]   shreg;      // Incoming byte
    logic [7:0]   reg_ptr;    // Selected register
    logic [7:0]   r_enable;   // Enable register
    logic [7:0]   r_main;     // Main level register
    logic [7:0]   r_aux;      // Aux level register
    logic [7:0]   r_ind;      // Indicator level register
    logic         boost;      // Pump at 3/2x
    ledbr_drive_t drv;        // Registered drive
    ledbr_sinks_t sns;        // Registered sense gating
  } ledbr_top_st_t;

  ledbr_top_st_t st;       // Current state
  ledbr_top_st_t next_st;  // Next state

  // Bus events
  logic scl_rise;   // SCL went high
  logic scl_fall;   // SCL went low
  logic start_ev;   // START or repeated START
  logic stop_ev;    // STOP
  logic addr_hit;   // Address byte is ours, write

  // Decoded enables
  logic main_en;    // Main sinks enabled
  logic aux_en;     // Aux sinks enabled
  logic ind_en;     // Indicator sink enabled
  logic five_en;    // Main sink five sensing
  logic third_en;   // Third aux sink drive and sense

  // Monitored sinks and dimming
  ledbr_sinks_t monitored;  // Sinks steering the gain
  logic         main_on;    // Main PWM phase
  logic         aux_on;     // Aux PWM phase
  logic [1:0]   main_sc;    // Main analog scale
  logic [1:0]   aux_sc;     // Aux analog scale
  logic [6:0]   own_addr;   // Active slave address

  // Main bank dimmer
  ledbr_pwm #(
    .PERIOD_CYC (`LEDBR_PWM_CYC),
    .SLOTS      (`LEDBR_PWM_SLOTS)
  ) u_main_pwm (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .level  (st.r_main[4:0]),
    .pwm_on (main_on),
    .scale  (main_sc)
  );

  // Aux bank dimmer
  ledbr_pwm #(
    .PERIOD_CYC (`LEDBR_PWM_CYC),
    .SLOTS      (`LEDBR_PWM_SLOTS)
  ) u_aux_pwm (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .level  (st.r_aux[4:0]),
    .pwm_on (aux_on),
    .scale  (aux_sc)
  );

  // Edge and condition detection on synced pins
  always_comb begin
    scl_rise = st.scl_s2 & ~st.scl_d;
    scl_fall = ~st.scl_s2 & st.scl_d;
    // SDA moving with SCL high is a bus condition
    start_ev = st.scl_s2 & st.scl_d & st.sda_d & ~st.sda_s2;
    stop_ev  = st.scl_s2 & st.scl_d & ~st.sda_d & st.sda_s2;
  end

  // Address selection and match
  always_comb begin
    own_addr = st.addr_alt ? `LEDBR_ADDR_ALT : `LEDBR_ADDR_STD;
    // Read direction is not served, so it is treated as a miss
    addr_hit = (st.shreg[7:1] == own_addr) & ~st.shreg[0];
  end

  // Enable decode
  always_comb begin
    main_en  = st.r_enable[`LEDBR_BIT_MAIN_EN];
    aux_en   = st.r_enable[`LEDBR_BIT_AUX_EN];
    ind_en   = st.r_enable[`LEDBR_BIT_IND_EN];
    five_en  = st.r_enable[`LEDBR_BIT_FIVE_SNS];
    third_en = st.r_enable[`LEDBR_BIT_THIRD_EN];
  end

  // Which sinks may pull the pump gain up
  always_comb begin
    // Sink five of main keeps its drive; only sensing is gated
    monitored.main = {main_en & five_en, {4{main_en}}};
    // Third aux sink is gated for drive and sensing alike
    monitored.aux  = {aux_en & third_en, {2{aux_en}}};
    // Indicator has no place in this vector at all
  end

  // Next-state logic
  always_comb begin
    next_st = st;

    // Two-flop synchronisers, stage 1 read only by stage 2
    next_st.scl_s1   = scl_in;
    next_st.scl_s2   = st.scl_s1;
    next_st.scl_d    = st.scl_s2;
    next_st.sda_s1   = sda_in;
    next_st.sda_s2   = st.sda_s1;
    next_st.sda_d    = st.sda_s2;
    next_st.rst_s1   = hw_reset_n;
    next_st.rst_s2   = st.rst_s1;
    next_st.strap_s1 = addr_alt_strap;
    next_st.strap_s2 = st.strap_s1;
    next_st.hr_s1    = headroom_low;
    next_st.hr_s2    = st.hr_s1;

    // Catch the strap once the synchroniser holds real data
    if (st.strap_cnt != 2'h3) begin
      next_st.strap_cnt = st.strap_cnt + 2'h1;
    end
    if (st.strap_cnt == 2'h2) begin
      next_st.addr_alt = st.strap_s2;
    end

    // Serial protocol
    if (start_ev) begin
      // Fresh or repeated START, both restart address reception
      next_st.phase     = LEDBR_ADDR;
      next_st.bitcnt    = 4'h0;
      next_st.ack_phase = 1'b0;
      next_st.ack_drive = 1'b0;
    end else if (stop_ev) begin
      // Bus free again
      next_st.phase     = LEDBR_IDLE;
      next_st.bitcnt    = 4'h0;
      next_st.ack_phase = 1'b0;
      next_st.ack_drive = 1'b0;
    end else if (st.phase != LEDBR_IDLE) begin
      // Sample on rising SCL, data settled while SCL was low
      if (scl_rise && !st.ack_phase && st.bitcnt < 4'h8) begin
        next_st.shreg  = {st.shreg[6:0], st.sda_s2};
        next_st.bitcnt = st.bitcnt + 4'h1;
      end
      if (scl_fall) begin
        if (st.ack_phase) begin
          // Ninth clock over; release SDA on its low phase
          next_st.ack_phase = 1'b0;
          next_st.ack_drive = 1'b0;
          next_st.bitcnt    = 4'h0;
        end else if (st.bitcnt == 4'h8) begin
          // Byte complete; ninth clock follows
          next_st.ack_phase = 1'b1;
          case (st.phase)
            LEDBR_ADDR: begin
              if (addr_hit) begin
                next_st.ack_drive = 1'b1;
                next_st.phase     = LEDBR_REG;
              end else begin
                // Not ours: stay off the bus until next START
                next_st.phase = LEDBR_SKIP;
              end
            end
            LEDBR_REG: begin
              next_st.reg_ptr   = st.shreg;
              next_st.ack_drive = 1'b1;
              next_st.phase     = LEDBR_DATA;
            end
            LEDBR_DATA: begin
              // Further bytes rewrite the same register
              next_st.ack_drive = 1'b1;
              case (st.reg_ptr)
                `LEDBR_OFS_ENABLE: begin
                  next_st.r_enable = (`LEDBR_RST_ENABLE & ~`LEDBR_WMASK_ENABLE)
                                   | (st.shreg & `LEDBR_WMASK_ENABLE);
                end
                `LEDBR_OFS_MAIN: begin
                  next_st.r_main = (`LEDBR_RST_MAIN & ~`LEDBR_WMASK_LEVEL)
                                 | (st.shreg & `LEDBR_WMASK_LEVEL);
                end
                `LEDBR_OFS_AUX: begin
                  next_st.r_aux = (`LEDBR_RST_AUX & ~`LEDBR_WMASK_LEVEL)
                                | (st.shreg & `LEDBR_WMASK_LEVEL);
                end
                `LEDBR_OFS_IND: begin
                  next_st.r_ind = (`LEDBR_RST_IND & ~`LEDBR_WMASK_IND)
                                | (st.shreg & `LEDBR_WMASK_IND);
                end
                default: begin
                  // Unmapped register: acknowledged, data dropped
                  next_st.r_enable = st.r_enable;
                end
              endcase
            end
            default: begin
              // Skipping: no acknowledge driven
              next_st.ack_drive = 1'b0;
            end
          endcase
        end
      end
    end

    // Pump gain: any monitored sink short of headroom asks for 3/2x
    if (|(monitored & st.hr_s2)) begin
      next_st.boost = 1'b1;
    end else if (!main_en && !aux_en) begin
      // With both banks off nothing needs the boost
      next_st.boost = 1'b0;
    end

    // Registered sink drive follows enables, and PWM phase for the two banks
    next_st.drv.main = {5{main_en & main_on}};
    next_st.drv.aux  = {third_en, 2'b11} & {3{aux_en & aux_on}};
    next_st.drv.ind  = ind_en;
    next_st.sns      = monitored;

    // Reset pin low: defaults, drivers off, bus released
    if (!st.rst_s2) begin
      next_st.r_enable  = `LEDBR_RST_ENABLE;
      next_st.r_main    = `LEDBR_RST_MAIN;
      next_st.r_aux     = `LEDBR_RST_AUX;
      next_st.r_ind     = `LEDBR_RST_IND;
      next_st.reg_ptr   = 8'h00;
      next_st.phase     = LEDBR_IDLE;
      next_st.bitcnt    = 4'h0;
      next_st.ack_phase = 1'b0;
      next_st.ack_drive = 1'b0;
      next_st.boost     = 1'b0;
      next_st.drv       = '0;
      // Sensing drops at once, so no stale sense bit outlives the pump reset
      next_st.sns       = '0;
    end
  end

  // State register; pin syncs start at their idle level
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st          <= '0;
      st.scl_s1   <= 1'b1;
      st.scl_s2   <= 1'b1;
      st.scl_d    <= 1'b1;
      st.sda_s1   <= 1'b1;
      st.sda_s2   <= 1'b1;
      st.sda_d    <= 1'b1;
      st.rst_s1   <= 1'b1;
      st.rst_s2   <= 1'b1;
      st.r_enable <= `LEDBR_RST_ENABLE;
      st.r_main   <= `LEDBR_RST_MAIN;
      st.r_aux    <= `LEDBR_RST_AUX;
      st.r_ind    <= `LEDBR_RST_IND;
    end else begin
      st <= next_st;
    end
  end

  // Open-drain data pin: only ever pulls low, never makes conditions
  assign sda_out = 1'b0;
  assign sda_oe  = st.ack_drive;

  // Outputs from state
  assign drive      = st.drv;
  assign sense_en   = st.sns;
  assign gain_boost = st.boost;
  // Indicator scale is its level code, analog only
  assign scale.main = main_sc;
  assign scale.aux  = aux_sc;
  assign scale.ind  = st.r_ind[1:0];

  // Register views
  assign enable_control      = st.r_enable;
  assign main_bank_level_reg = st.r_main;
  assign aux_bank_level_reg  = st.r_aux;
  assign indicator_level_reg = st.r_ind;

endmodule

//--- verilog/ledbr_defs.svh
// Purpose: Constants of the LED brightness I2C slave.
// Assumes: 40 MHz mclk; 7-bit I2C addressing.
// Notes:   Offsets, reset values and timing counts live here only.
`ifndef LEDBR_DEFS_SVH
`define LEDBR_DEFS_SVH

// Slave addresses
`define LEDBR_ADDR_STD      7'h36
`define LEDBR_ADDR_ALT      7'h38

// Register offsets
`define LEDBR_OFS_ENABLE    8'h10
`define LEDBR_OFS_MAIN      8'hA0
`define LEDBR_OFS_AUX       8'hB0
`define LEDBR_OFS_IND       8'hC0

// Reset values
`define LEDBR_RST_ENABLE    8'h20
`define LEDBR_RST_MAIN      8'hE0
`define LEDBR_RST_AUX       8'hE0
`define LEDBR_RST_IND       8'hFC

// Writable bits of each register
`define LEDBR_WMASK_ENABLE  8'h1F
`define LEDBR_WMASK_LEVEL   8'h1F
`define LEDBR_WMASK_IND     8'h03

// Enable register field positions
`define LEDBR_BIT_MAIN_EN   0
`define LEDBR_BIT_AUX_EN    1
`define LEDBR_BIT_IND_EN    2
`define LEDBR_BIT_FIVE_SNS  3
`define LEDBR_BIT_THIRD_EN  4

// Timing
`define LEDBR_CLK_HZ        40000000
`define LEDBR_PWM_HZ        20000
`define LEDBR_PWM_CYC       (`LEDBR_CLK_HZ / `LEDBR_PWM_HZ)
`define LEDBR_PWM_SLOTS     16

`endif

//--- verilog/ledbr_pkg.sv
// Purpose: Types shared by the LED brightness slave.
// Assumes: Constants come from ledbr_defs.svh.
// Notes:   State structs hold each module's whole state.
package ledbr_pkg;

  // Transaction phase of the serial slave
  typedef enum logic [2:0] {
    LEDBR_IDLE,
    LEDBR_ADDR,
    LEDBR_REG,
    LEDBR_DATA,
    LEDBR_SKIP
  } ledbr_phase_t;

  // Per-sink flags: main bank five sinks, aux bank three
  typedef struct packed {
    logic [2:0] aux;
    logic [4:0] main;
  } ledbr_sinks_t;

  // Sink drive commands
  typedef struct packed {
    logic [2:0] aux;
    logic [4:0] main;
    logic       ind;
  } ledbr_drive_t;

  // Analog scale codes, 0=20% 1=40% 2=70% 3=100%
  typedef struct packed {
    logic [1:0] main;
    logic [1:0] aux;
    logic [1:0] ind;
  } ledbr_scale_t;

  // PWM generator state
  typedef struct packed {
    logic [15:0] cnt;
    logic [4:0]  slot;
    logic        on;
    logic [1:0]  scale;
  } ledbr_pwm_st_t;

endpackage

//--- verilog/ledbr_pwm.sv
// Purpose: One bank's 32-level dimming, analog scale plus PWM.
// Assumes: PERIOD_CYC clocks per PWM period, split into SLOTS.
// Notes:   Duty steps are sixteenths; level maps to scale and duty.
`include "ledbr_defs.svh"

module ledbr_pwm #(
  parameter int PERIOD_CYC = `LEDBR_PWM_CYC,
  parameter int SLOTS      = `LEDBR_PWM_SLOTS
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Brightness code
  input  wire logic [4:0] level,
  // Dimming outputs
  output logic            pwm_on,
  output logic [1:0]      scale
);
  import ledbr_pkg::*;

  localparam int SLOT_CYC = PERIOD_CYC / SLOTS;

  // Refuse periods the counters cannot hold
  if (SLOTS != 16 || SLOT_CYC < 1 || SLOT_CYC > 65535) begin : g_bad
    $error("ledbr_pwm: unsupported PWM period or slot count");
  end

  ledbr_pwm_st_t st;       // Whole state
  ledbr_pwm_st_t next_st;  // Next state
  logic [4:0]    duty;     // On slots, 1..16
  logic [1:0]    code_sc;  // Analog scale of code

  // Code to analog scale and duty, monotonic brightness
  always_comb begin
    if (level <= 5'h0F) begin
      code_sc = 2'h0;
      duty    = level + 5'h01;
    end else if (level <= 5'h16) begin
      code_sc = 2'h1;
      duty    = level - 5'h06;
    end else if (level <= 5'h1C) begin
      code_sc = 2'h2;
      duty    = level - 5'h0C;
    end else if (level == 5'h1D) begin
      code_sc = 2'h3;
      duty    = 5'h0D;
    end else if (level == 5'h1E) begin
      code_sc = 2'h3;
      duty    = 5'h0F;
    end else begin
      code_sc = 2'h3;
      duty    = 5'h10;
    end
  end

  // Slot timebase, fixed frequency whatever the code
  always_comb begin
    next_st = st;
    if (st.cnt == 16'(SLOT_CYC - 1)) begin
      next_st.cnt  = 16'h0000;
      next_st.slot = (st.slot == 5'h0F) ? 5'h00 : st.slot + 5'h01;
    end else begin
      next_st.cnt = st.cnt + 16'h0001;
    end
    next_st.on    = (st.slot < duty);
    next_st.scale = code_sc;
  end

  // State register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pwm_on = st.on;
  assign scale  = st.scale;

endmodule

//--- tb/ledbr_asserts.sv
// Purpose: Port assertions for the LED brightness slave.
// Assumes: One mclk domain; rst_n sync, active low.
// Notes:   Outputs may lag the registers by one stage.
module ledbr_asserts (
  // Clock and resets
  input wire logic                    mclk,
  input wire logic                    rst_n,
  input wire logic                    hw_reset_n,
  // Bus pins
  input wire logic                    scl_in,
  input wire logic                    sda_oe,
  // Analog side
  input wire ledbr_pkg::ledbr_sinks_t headroom_low,
  input wire ledbr_pkg::ledbr_sinks_t sense_en,
  input wire ledbr_pkg::ledbr_drive_t drive,
  input wire ledbr_pkg::ledbr_scale_t scale,
  input wire logic                    gain_boost,
  // Register views
  input wire logic [7:0]              enable_control,
  input wire logic [7:0]              main_bank_level_reg,
  input wire logic [7:0]              aux_bank_level_reg,
  input wire logic [7:0]              indicator_level_reg
);
  timeunit 1ns;
  timeprecision 1ps;
  import ledbr_pkg::*;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  logic [7:0] en_q;   // Enables one sample back
  logic [7:0] en_qq;  // Enables two samples back
  logic       steady; // Enables unchanged long enough to settle
  logic [4:0] e;      // Live enable bits
  // Analog band of a bank level code, from the brightness table
  function automatic logic [1:0] band(input logic [4:0] c);
    band = (c <= 5'h0F) ? 2'h0 : (c <= 5'h16) ? 2'h1 : (c <= 5'h1C) ? 2'h2 : 2'h3;
  endfunction
  assign e = enable_control[4:0];
  assign steady = enable_control == en_q && en_q == en_qq;
  // History, so outputs one stage behind are not flagged
  always_ff @(posedge mclk) begin
    en_q <= enable_control;
    en_qq <= en_q;
  end
  rst_defaults_a: assert property (!hw_reset_n [*4] |->
    {enable_control, main_bank_level_reg, aux_bank_level_reg, indicator_level_reg}
    == 32'h20E0E0FC && drive == '0 && !gain_boost)
    else $error("Pin reset left non-default state");
  fixed_bits_a: assert property (enable_control[7:5] == 3'h1
    && main_bank_level_reg[7:5] == 3'h7 && aux_bank_level_reg[7:5] == 3'h7
    && indicator_level_reg[7:2] == 6'h3F)
    else $error("Unused register bits changed");
  ack_when_low_a: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("Ack line moved while clock high");
  ack_stands_a: assert property ($rose(scl_in) && sda_oe |=> sda_oe [*2])
    else $error("Ack released during clock high");
  sense_gate_a: assert property (steady |-> sense_en ==
    {e[1] & e[4], {2{e[1]}}, e[0] & e[3], {4{e[0]}}})
    else $error("Sense gating does not match enables");
  drive_gate_a: assert property (steady |-> (drive.main == '0 || e[0])
    && (drive.aux[1:0] == '0 || e[1]) && (!drive.aux[2] || e[1] & e[4])
    && (!drive.ind || e[2]))
    else $error("Sink driven while disabled");
  gain_rise_a: assert property ((|(headroom_low & sense_en)) [*6] |-> gain_boost)
    else $error("Low headroom did not raise gain");
  ind_scale_a: assert property ($stable(indicator_level_reg) |->
    scale.ind == indicator_level_reg[1:0])
    else $error("Indicator scale differs from its code");
  level_scale_a: assert property ($stable(main_bank_level_reg)
    && $stable(aux_bank_level_reg) |-> scale.main == band(main_bank_level_reg[4:0])
    && scale.aux == band(aux_bank_level_reg[4:0]))
    else $error("Bank scale does not match its level code");
endmodule

//--- tb/ledbr_host.sv
// Purpose: Bus master model for the LED brightness slave.
// Assumes: Pull-up on the data line; 8 mclk per bus bit, plus slow extra cycles in the low phase.
// Notes:   Clock line idles high between frames.
module ledbr_host (
  // Clock
  input  wire logic mclk,
  // Bus pins
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda_line
);
  timeunit 1ns;
  timeprecision 1ps;
  int   slow = 0;         // Extra low-phase cycles for a slow master
  logic in_frame = 1'b0;  // Next START is a repeated one
  // Idle bus: both lines released
  initial begin
    scl <= 1'b1;
    sda_drv <= 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Data moves one edge after the clock falls, never while high
  task automatic send_bit(input logic b, output logic seen);
    scl <= 1'b0;
    tick(1);
    sda_drv <= b;
    tick(4 + slow);
    scl <= 1'b1;
    tick(3);
    seen = sda_line;
  endtask
  // Eight bits MSB first, then a released ninth bit
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) send_bit(b[i], s);
    send_bit(1'b1, s);
    ack = !s;
  endtask
  // Inside a frame the clock is parked low first
  task automatic start_cond();
    tick(1);
    if (in_frame) begin
      scl <= 1'b0;
      tick(1);
      sda_drv <= 1'b1;
      tick(4);
      scl <= 1'b1;
      tick(3);
    end
    sda_drv <= 1'b0;
    tick(4);
    in_frame = 1'b1;
  endtask
  // Data rises while the clock is high
  task automatic stop_cond();
    scl <= 1'b0;
    tick(1);
    sda_drv <= 1'b0;
    tick(4);
    scl <= 1'b1;
    tick(3);
    sda_drv <= 1'b1;
    tick(4);
    in_frame = 1'b0;
  endtask
endmodule

//--- tb/testbench.sv
// Purpose: Self-checking bench for the LED brightness slave.
// Assumes: 40 MHz mclk; bus traffic from the master model.
// Notes:   Open-drain data line modelled as a wired AND.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import ledbr_pkg::*;
  logic         mclk, rst_n, hw_reset_n, strap;  // Clock, resets, strap
  logic         scl, sda_drv, sda_line;          // Bus wires
  logic         sda_out, sda_oe, gain_boost, a;  // Ack and gain
  ledbr_sinks_t headroom_low, sense_en;          // Headroom flags, sensing
  ledbr_drive_t drive;                           // Sink commands
  ledbr_scale_t scale;                           // Analog scales
  logic [7:0]   en_r, main_r, aux_r, ind_r;      // Register views
  int           mismatches, tests_run, cycles, cnt;
  // Per write: first byte, offset, data, ack, then four registers
  logic [7:0]   tbl [9][8] = '{
    '{8'h6C, 8'h10, 8'hFF, 8'h01, 8'h3F, 8'hE0, 8'hE0, 8'hFC},
    '{8'h6C, 8'hA0, 8'hFF, 8'h01, 8'h3F, 8'hFF, 8'hE0, 8'hFC},
    '{8'h6C, 8'hB0, 8'h4A, 8'h01, 8'h3F, 8'hFF, 8'hEA, 8'hFC},
    '{8'h6C, 8'hC0, 8'h02, 8'h01, 8'h3F, 8'hFF, 8'hEA, 8'hFE},
    '{8'h6C, 8'h20, 8'h55, 8'h01, 8'h3F, 8'hFF, 8'hEA, 8'hFE},
    '{8'h6E, 8'hA0, 8'h00, 8'h00, 8'h3F, 8'hFF, 8'hEA, 8'hFE},
    '{8'h6D, 8'hA0, 8'h00, 8'h00, 8'h3F, 8'hFF, 8'hEA, 8'hFE},
    '{8'h70, 8'hA0, 8'h00, 8'h00, 8'h3F, 8'hFF, 8'hEA, 8'hFE},
    '{8'h6C, 8'h10, 8'h00, 8'h01, 8'h20, 8'hFF, 8'hEA, 8'hFE}};
  assign sda_line = sda_drv && !(sda_oe && !sda_out);
  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;
  ledbr_top ledbr_top_i (.mclk(mclk), .rst_n(rst_n), .hw_reset_n(hw_reset_n),
    .addr_alt_strap(strap), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .headroom_low(headroom_low), .drive(drive), .scale(scale),
    .sense_en(sense_en), .gain_boost(gain_boost), .enable_control(en_r),
    .main_bank_level_reg(main_r), .aux_bank_level_reg(aux_r),
    .indicator_level_reg(ind_r));
  ledbr_host ledbr_host_i (.mclk(mclk), .scl(scl), .sda_drv(sda_drv),
    .sda_line(sda_line));
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Hang guard, well above the expected run length
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      wrap_up();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Three-byte write; every ack must match the expectation
  task automatic wr(input logic [7:0] fb, ra, d, input logic ack);
    logic [7:0] b [3];
    b = '{fb, ra, d};
    ledbr_host_i.start_cond();
    foreach (b[k]) begin
      ledbr_host_i.send_byte(b[k], a);
      check("ack", 32'(ack), 32'(a));
    end
    ledbr_host_i.stop_cond();
  endtask
  // Enable write, then sensing and gain once flags have settled
  task automatic ens(input logic [7:0] e, s, input logic g);
    wr(8'h6C, 8'h10, e, 1'b1);
    tick(8);
    check("sense", 32'(s), 32'(sense_en));
    check("gain", 32'(g), 32'(gain_boost));
  endtask
  // Level write, one settling period, then one period of duty count
  task automatic duty(input logic [7:0] code, input int exp);
    wr(8'h6C, 8'hA0, code, 1'b1);
    tick(2000);
    cnt = 0;
    repeat (2000) begin
      @(negedge mclk);
      cnt += int'(drive.main[0]);
    end
    check("main duty", 32'(exp), 32'(cnt));
  endtask
  initial begin
    {rst_n, hw_reset_n, strap, headroom_low} <= {1'b0, 1'b1, 1'b0, 8'h00};
    tick(3);
    rst_n <= 1'b1;
    tick(4);
    check("defaults", 32'h20E0E0FC, {en_r, main_r, aux_r, ind_r});
    foreach (tbl[r]) begin
      wr(tbl[r][0], tbl[r][1], tbl[r][2], tbl[r][3][0]);
      check("regs", {tbl[r][4], tbl[r][5], tbl[r][6], tbl[r][7]},
        {en_r, main_r, aux_r, ind_r});
    end
    // Restart mid-write retargets; extra data rewrites the register
    ledbr_host_i.start_cond();
    ledbr_host_i.send_byte(8'h6C, a);
    ledbr_host_i.send_byte(8'hA0, a);
    ledbr_host_i.start_cond();
    for (int k = 0; k < 4; k++) ledbr_host_i.send_byte(8'h6C + 8'(k * 'h44), a);
    ledbr_host_i.stop_cond();
    check("restart", 32'h20FFF8FE, {en_r, main_r, aux_r, ind_r});
    ledbr_host_i.send_byte(8'h6C, a);
    check("idle ack", 32'h0, 32'(a));
    for (int c = 0; c < 4; c++) begin
      wr(8'h6C, 8'hC0, 8'(c), 1'b1);
      check("ind scale", 32'(c), 32'(scale.ind));
    end
    for (int c = 0; c < 4; c++) begin
      wr(8'h6C, 8'hA0, 8'({8'h0F, 8'h10, 8'h1C, 8'h1D} >> (24 - 8 * c)), 1'b1);
      check("main scale", 32'(c), 32'(scale.main));
    end
    wr(8'h6C, 8'h10, 8'h01, 1'b1);
    duty(8'h00, 125);
    duty(8'h17, 1375);
    duty(8'h1F, 2000);
    tick(1);
    headroom_low <= 8'hF0;
    ens(8'h01, 8'h0F, 1'b0);
    ens(8'h09, 8'h1F, 1'b1);
    ens(8'h12, 8'hE0, 1'b1);
    ens(8'h02, 8'h60, 1'b1);
    ens(8'h00, 8'h00, 1'b0);
    ens(8'h04, 8'h00, 1'b0);
    check("ind drive", 32'h1, 32'(drive.ind));
    ens(8'h09, 8'h1F, 1'b1);
    hw_reset_n <= 1'b0;
    tick(4);
    hw_reset_n <= 1'b1;
    tick(4);
    check("pin reset", 32'h20E0E0FC, {en_r, main_r, aux_r, ind_r});
    check("pin reset gain", 32'h0, 32'(gain_boost));
    {strap, rst_n, headroom_low} <= {1'b1, 1'b0, 8'h00};
    tick(3);
    rst_n <= 1'b1;
    tick(4);
    ledbr_host_i.slow = 6;
    wr(8'h70, 8'hA0, 8'h11, 1'b1);
    wr(8'h6C, 8'hA0, 8'h00, 1'b0);
    check("alt write", 32'hF1, 32'(main_r));
    wrap_up();
  end
endmodule
bind ledbr_top ledbr_asserts ledbr_asserts_i (.mclk(mclk), .rst_n(rst_n),
  .hw_reset_n(hw_reset_n), .scl_in(scl_in), .sda_oe(sda_oe),
  .headroom_low(headroom_low), .sense_en(sense_en), .drive(drive), .scale(scale),
  .gain_boost(gain_boost), .enable_control(enable_control),
  .main_bank_level_reg(main_bank_level_reg), .aux_bank_level_reg(aux_bank_level_reg),
  .indicator_level_reg(indicator_level_reg));
